// ==== core/logical_or_pkg.sv ====
package logical_or_pkg;

    // Instruction word fields
    localparam int GRP_MSB    = 15;
    localparam int GRP_LSB    = 12;
    localparam int DREG_MSB   = 11;
    localparam int DREG_LSB   = 9;
    localparam int OPMODE_MSB = 8;
    localparam int OPMODE_LSB = 6;
    localparam int SIZE_MSB   = 7;
    localparam int SIZE_LSB   = 6;
    localparam int MODE_MSB   = 5;
    localparam int MODE_LSB   = 3;
    localparam int REG_MSB    = 2;
    localparam int REG_LSB    = 0;
    localparam int HIGH_MSB   = 15;
    localparam int HIGH_LSB   = 8;

    localparam logic [3:0]  OR_GROUP        = 4'hc;
    localparam logic [7:0]  IMM_GROUP       = 8'h00;
    localparam logic [15:0] FLAG_FORM_WORD  = 16'h003c;

    // Effective address modes and mode-7 sub-registers
    localparam logic [2:0] MODE_DREG  = 3'h0;
    localparam logic [2:0] MODE_AREG  = 3'h1;
    localparam logic [2:0] MODE_IND   = 3'h2;
    localparam logic [2:0] MODE_IDX   = 3'h6;
    localparam logic [2:0] MODE_EXT   = 3'h7;
    localparam logic [2:0] EXT_ABS_W  = 3'h0;
    localparam logic [2:0] EXT_ABS_L  = 3'h1;
    localparam logic [2:0] EXT_PC_D16 = 3'h2;
    localparam logic [2:0] EXT_PC_IDX = 3'h3;
    localparam logic [2:0] EXT_IMM    = 3'h4;

    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic [1:0] SIZE_BAD  = 2'h3;

    // Condition code byte layout
    localparam int FLAG_X = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAG_IMPL_MASK = 8'h1f;
    localparam logic [7:0] FLAG_RST       = 8'h00;

    // Register port map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_DREG_BASE = 8'h00;
    localparam logic [7:0] OFS_DREG_LAST = 8'h1c;
    localparam logic [7:0] OFS_FLAGS     = 8'h20;
    localparam logic [7:0] OFS_STATUS    = 8'h24;
    localparam logic [7:0] OFS_CTRL      = 8'h28;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_ILLEGAL = 1;
    localparam int CTRL_ENABLE  = 0;
    localparam logic       CTRL_EN_RST = 1'b1;
    localparam logic [31:0] DREG_RST   = 32'h0000_0000;

    typedef enum {S_IDLE, S_EXT, S_READ, S_EXEC, S_WRITE} state_t;

endpackage : logical_or_pkg

// ==== core/logical_or_execute.sv ====
// Behaviour
// RULE1 - OR register/memory operands, write destination
// RULE2 - Address registers never usable as operands
// RULE3 - Flags: X kept, N, Z, V=C=0
// RULE4 - Decode group 1100, register, opmode
// RULE5 - Source ea limited to data modes
// RULE6 - Destination ea limited to memory alterable
// RULE7 - Register destination only via register opmodes
// RULE8 - Immediate ORed into destination, same size
// RULE9 - Decode immediate form, bits 15-8 zero
// RULE10 - Immediate destination limited to data alterable
// RULE11 - Immediate taken from one or two words
// RULE12 - Immediate form flags: X kept, N, Z, V=C=0
// RULE13 - Byte immediate ORed into condition byte
// RULE14 - Flags X N Z V C at bits 4-0
// RULE15 - Only condition byte bits are affected
// RULE16 - N from size msb, Z over size
//
// The implementer's own choices: the plain strobed port and the address map.
module logical_or_execute
    import logical_or_pkg::*;
(
    input  wire logic              mclk,       // Core clock
    input  wire logic              arst_n,     // Asynchronous reset
    input  wire logic [15:0]       opWord,     // First instruction word
    input  wire logic              opValid,    // First word offered
    output logic                   opReady,    // First word taken
    output logic                   extReq,     // Wants next extension word
    input  wire logic [15:0]       extWord,    // Extension word
    input  wire logic              extValid,   // Extension word present
    output logic                   memRdReq,   // Read ea operand
    output logic                   memWrReq,   // Store result to ea
    output logic [2:0]             eaMode,     // Ea mode for the bus unit
    output logic [2:0]             eaReg,      // Ea register for the bus unit
    output logic [1:0]             memSize,    // Operand size
    input  wire logic [31:0]       memRdData,  // Operand read back
    input  wire logic              memRdValid, // Read data present
    output logic [31:0]            memWrData,  // Result to store
    input  wire logic              memWrAck,   // Store completed
    output logic                   illegal,    // Rejected opcode pulse
    output logic                   done,       // Instruction retired pulse
    output logic [7:0]             flagByte,   // Condition code byte
    input  wire logic [ADDR_W-1:0] regAddr,    // Register address
    input  wire logic [31:0]       regWrData,  // Register write data
    input  wire logic              regWr,      // Register write strobe
    input  wire logic              regRd,      // Register read strobe
    output logic [31:0]            regRdData   // Read data, next cycle
);

    function automatic logic [31:0] sizeMask(input logic [1:0] sz);
        case (sz)
            SIZE_BYTE: sizeMask = 32'h0000_00ff;
            SIZE_WORD: sizeMask = 32'h0000_ffff;
            default:   sizeMask = 32'hffff_ffff;
        endcase
    endfunction : sizeMask

    function automatic logic msbOf(input logic [31:0] v, input logic [1:0] sz);
        case (sz)
            SIZE_BYTE: msbOf = v[7];
            SIZE_WORD: msbOf = v[15];
            default:   msbOf = v[31];
        endcase
    endfunction : msbOf

    // Memory alterable: (An) through indexed, absolute short/long
    function automatic logic memAlterable(input logic [2:0] m, input logic [2:0] r);
        memAlterable = (m >= MODE_IND && m <= MODE_IDX) ||
                       (m == MODE_EXT && (r == EXT_ABS_W || r == EXT_ABS_L));
    endfunction : memAlterable

    function automatic logic dataSource(input logic [2:0] m, input logic [2:0] r);
        dataSource = (m == MODE_DREG) || memAlterable(m, r) ||
                     (m == MODE_EXT && (r == EXT_PC_D16 || r == EXT_PC_IDX || r == EXT_IMM));
    endfunction : dataSource

    state_t      state_q;
    logic [31:0] dreg_q [8];
    logic [7:0]  flags_q;
    logic        ctrlEn_q;
    logic        illSeen_q;

    // Latched instruction
    logic        isFlag_q, isRegMem_q, destMem_q, needRead_q, immEa_q;
    logic [1:0]  size_q;
    logic [2:0]  dreg_sel_q;
    logic [2:0]  mode_q, reg_q;
    logic        extLeft_q;
    logic [31:0] imm_q;
    logic [31:0] opnd_q;

    // Decode of the offered word
    logic       dFlag, dRegMem, dLegal, dDestMem, dNeedImm, dNeedRead, dImmEa, dLong;
    logic [1:0] dSize;
    logic [2:0] dMode, dReg;

    always_comb begin
        dMode     = opWord[MODE_MSB:MODE_LSB];
        dReg      = opWord[REG_MSB:REG_LSB];
        dFlag     = (opWord == FLAG_FORM_WORD);                                      // RULE13
        dRegMem   = (opWord[GRP_MSB:GRP_LSB] == OR_GROUP);                           // RULE4
        dLegal    = 1'b0;
        dDestMem  = 1'b0;
        dNeedImm  = 1'b0;
        dNeedRead = 1'b0;
        dImmEa    = 1'b0;
        dSize     = SIZE_BYTE;
        if (dFlag) begin
            dLegal   = 1'b1;
            dNeedImm = 1'b1;                                                         // RULE13
        end else if (dRegMem) begin
            dSize = opWord[OPMODE_MSB-1:OPMODE_LSB];                                 // RULE4
            if (!opWord[OPMODE_MSB]) begin
                dLegal    = dataSource(dMode, dReg) && dSize != SIZE_BAD;            // RULE5 RULE2
                dImmEa    = (dMode == MODE_EXT && dReg == EXT_IMM);
                dNeedImm  = dImmEa;
                dNeedRead = !dImmEa && dMode != MODE_DREG;
            end else begin
                // Data register destination is only reachable via the register opmodes
                dLegal    = memAlterable(dMode, dReg) && dSize != SIZE_BAD;          // RULE6 RULE7 RULE2
                dNeedRead = 1'b1;
                dDestMem  = 1'b1;
            end
        end else if (opWord[HIGH_MSB:HIGH_LSB] == IMM_GROUP) begin
            dSize     = opWord[SIZE_MSB:SIZE_LSB];                                   // RULE9
            dLegal    = (dMode == MODE_DREG || memAlterable(dMode, dReg)) && dSize != SIZE_BAD; // RULE10
            dNeedImm  = 1'b1;                                                        // RULE8
            dNeedRead = dMode != MODE_DREG;
            dDestMem  = dMode != MODE_DREG;
        end
        dLong = (dSize == SIZE_LONG);
    end

    assign opReady  = (state_q == S_IDLE) && ctrlEn_q;
    assign extReq   = (state_q == S_EXT);
    assign memRdReq = (state_q == S_READ);
    assign memWrReq = (state_q == S_WRITE);
    assign flagByte = flags_q;

    logic accept;
    assign accept = opValid && opReady;

    // Execute datapath
    logic [31:0] eaVal, otherVal, result;
    logic [2:0]  wrIdx;
    logic        regDest;

    always_comb begin
        if (mode_q == MODE_DREG)
            eaVal = dreg_q[reg_q];
        else if (immEa_q)
            eaVal = imm_q;
        else
            eaVal = opnd_q;
        otherVal = isRegMem_q ? dreg_q[dreg_sel_q] : imm_q;
        result   = (eaVal | otherVal) & sizeMask(size_q);                            // RULE1 RULE8
        regDest  = !isFlag_q && !destMem_q;
        wrIdx    = isRegMem_q ? dreg_sel_q : reg_q;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (accept && dLegal)
                        state_q <= dNeedImm ? S_EXT : (dNeedRead ? S_READ : S_EXEC);
                end
                S_EXT: begin
                    if (extValid && !extLeft_q)
                        state_q <= needRead_q ? S_READ : S_EXEC;
                end
                S_READ: begin
                    if (memRdValid)
                        state_q <= S_EXEC;
                end
                S_EXEC: begin
                    state_q <= destMem_q ? S_WRITE : S_IDLE;
                end
                S_WRITE: begin
                    if (memWrAck)
                        state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            isFlag_q   <= 1'b0;
            isRegMem_q <= 1'b0;
            destMem_q  <= 1'b0;
            needRead_q <= 1'b0;
            immEa_q    <= 1'b0;
            size_q     <= SIZE_BYTE;
            dreg_sel_q <= 3'h0;
            mode_q     <= MODE_DREG;
            reg_q      <= 3'h0;
            eaMode     <= MODE_DREG;
            eaReg      <= 3'h0;
            memSize    <= SIZE_BYTE;
        end else if (accept && dLegal) begin
            isFlag_q   <= dFlag;
            isRegMem_q <= dRegMem;
            destMem_q  <= dDestMem;
            needRead_q <= dNeedRead;
            immEa_q    <= dImmEa;
            size_q     <= dSize;
            dreg_sel_q <= opWord[DREG_MSB:DREG_LSB];
            mode_q     <= dMode;
            reg_q      <= dReg;
            eaMode     <= dMode;
            eaReg      <= dReg;
            memSize    <= dSize;
        end
    end

    // Long immediates arrive high word first; narrower sizes use one word
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            imm_q     <= 32'h0000_0000;
            extLeft_q <= 1'b0;
        end else if (accept && dLegal) begin
            imm_q     <= 32'h0000_0000;
            extLeft_q <= dLong && dNeedImm;                                          // RULE11
        end else if (state_q == S_EXT && extValid) begin
            imm_q     <= {imm_q[15:0], extWord};                                     // RULE11
            extLeft_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            opnd_q <= 32'h0000_0000;
        else if (state_q == S_READ && memRdValid)
            opnd_q <= memRdData;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            memWrData <= 32'h0000_0000;
        else if (state_q == S_EXEC)
            memWrData <= result;
    end

    // Execution write beats a software write to the same register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 8; i++)
                dreg_q[i] <= DREG_RST;
        end else begin
            if (regWr && regAddr <= OFS_DREG_LAST && regAddr[1:0] == 2'h0)
                dreg_q[regAddr[4:2]] <= regWrData;
            if (state_q == S_EXEC && regDest)
                dreg_q[wrIdx] <= (dreg_q[wrIdx] & ~sizeMask(size_q)) | result;       // RULE1
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= FLAG_RST;
        end else if (state_q == S_EXEC && isFlag_q) begin
            // Only the implemented low five bits exist; nothing above the byte
            flags_q <= (flags_q | imm_q[7:0]) & FLAG_IMPL_MASK;                      // RULE13 RULE14 RULE15
        end else if (state_q == S_EXEC) begin
            flags_q[FLAG_N] <= msbOf(result, size_q);                                // RULE3 RULE12 RULE16
            flags_q[FLAG_Z] <= (result == 32'h0000_0000);                            // RULE3 RULE12 RULE16
            flags_q[FLAG_V] <= 1'b0;                                                 // RULE3 RULE12
            flags_q[FLAG_C] <= 1'b0;                                                 // RULE3 RULE12
        end else if (regWr && regAddr == OFS_FLAGS) begin
            flags_q <= regWrData[7:0] & FLAG_IMPL_MASK;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            illegal <= 1'b0;
            done    <= 1'b0;
        end else begin
            illegal <= accept && !dLegal;                                            // RULE2
            done    <= (state_q == S_EXEC && !destMem_q) || (state_q == S_WRITE && memWrAck);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            ctrlEn_q <= CTRL_EN_RST;
        else if (regWr && regAddr == OFS_CTRL)
            ctrlEn_q <= regWrData[CTRL_ENABLE];
    end

    // Sticky; a rejection in the clearing cycle still sets it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            illSeen_q <= 1'b0;
        else if (accept && !dLegal)
            illSeen_q <= 1'b1;
        else if (regWr && regAddr == OFS_STATUS && regWrData[STAT_ILLEGAL])
            illSeen_q <= 1'b0;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 32'h0000_0000;
        end else if (regRd) begin
            if (regAddr <= OFS_DREG_LAST && regAddr[1:0] == 2'h0)
                regRdData <= dreg_q[regAddr[4:2]];
            else if (regAddr == OFS_FLAGS)
                regRdData <= {24'h000000, flags_q};
            else if (regAddr == OFS_STATUS)
                regRdData <= {30'h0, illSeen_q, state_q != S_IDLE};
            else if (regAddr == OFS_CTRL)
                regRdData <= {31'h0, ctrlEn_q};
            else
                regRdData <= 32'h0000_0000;
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

endmodule : logical_or_execute

// ==== tb/logical_or_execute_asserts.sv ====
module logical_or_execute_asserts
    import logical_or_pkg::*;
(
    input wire logic        mclk,       // Clock
    input wire logic        arst_n,     // Reset
    input wire logic [15:0] opWord,     // Word
    input wire logic        opValid,    // Offer
    input wire logic        opReady,    // Take
    input wire logic        memRdReq,   // Read
    input wire logic        memRdValid, // Read data
    input wire logic        memWrReq,   // Store
    input wire logic        memWrAck,   // Stored
    input wire logic [31:0] memWrData,  // Result
    input wire logic        illegal,    // Reject
    input wire logic        done,       // Retire
    input wire logic [7:0]  flagByte,   // Flags
    input wire logic        regRd,      // Read strobe
    input wire logic [31:0] regRdData   // Read data
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic       take;
    logic       badDst;
    logic       xKeep_q;
    logic       form_q;
    logic [2:0] md;
    assign take = opValid && opReady;
    assign md = opWord[MODE_MSB:MODE_LSB];
    assign badDst = md == MODE_EXT && opWord[2:1] != 2'h0;
    // Extend flag and form latched at accept, so retirement can be judged against them
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            xKeep_q <= 1'b0;
            form_q <= 1'b0;
        end else if (take) begin
            xKeep_q <= flagByte[FLAG_X];
            form_q <= opWord == FLAG_FORM_WORD;
        end
    end
    a_ready_drops: assert property (take |=> !opReady || illegal) else $error("opReady held after accept");
    a_illegal_pulse: assert property (illegal |=> !illegal) else $error("illegal longer than one cycle");
    a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
    a_flag_top: assert property (flagByte[7:5] == 3'h0) else $error("unused flag bits set");
    a_vc_cleared: assert property (done && !form_q |-> flagByte[1:0] == 2'h0)
        else $error("V or C set");
    a_extend_kept: assert property (done && !form_q |-> flagByte[FLAG_X] == xKeep_q)
        else $error("extend flag changed");
    a_areg_rejected: assert property (take && opWord[15:12] == OR_GROUP && md == MODE_AREG |=> illegal)
        else $error("address register accepted");
    a_dst_rejected: assert property (take && opWord[15:12] == OR_GROUP && opWord[8]
        && (md == MODE_DREG || md == MODE_AREG || badDst) |=> illegal) else $error("bad destination accepted");
    a_imm_rejected: assert property (take && opWord[15:8] == IMM_GROUP && opWord != FLAG_FORM_WORD
        && (md == MODE_AREG || badDst) |=> illegal) else $error("bad immediate destination accepted");
    a_form_legal: assert property (take && opWord == FLAG_FORM_WORD |=> !illegal)
        else $error("flag form refused");
    a_rd_hold: assert property (memRdReq && !memRdValid |=> memRdReq) else $error("read request dropped");
    a_wr_hold: assert property (memWrReq && !memWrAck |=> memWrReq && $stable(memWrData))
        else $error("store request unstable");
    a_rddata_zero: assert property (regRdData != 32'h0 |-> $past(regRd)) else $error("read data outside slot");
    c_reject: cover property (take ##1 illegal);
    c_store: cover property (memWrReq && memWrAck);
    c_form: cover property (done && form_q);
endmodule : logical_or_execute_asserts

bind logical_or_execute logical_or_execute_asserts u_logical_or_execute_asserts (.mclk(mclk), .arst_n(arst_n),
    .opWord(opWord), .opValid(opValid), .opReady(opReady), .memRdReq(memRdReq), .memRdValid(memRdValid),
    .memWrReq(memWrReq), .memWrAck(memWrAck), .memWrData(memWrData), .illegal(illegal), .done(done),
    .flagByte(flagByte), .regRd(regRd), .regRdData(regRdData));

// ==== tb/bus_unit_model.sv ====
module bus_unit_model
    import logical_or_pkg::*;
(
    input  wire logic        mclk,       // Clock
    input  wire logic        arst_n,     // Reset
    input  wire logic        slow,       // Answer every other cycle
    input  wire logic [31:0] immData,    // Immediate to hand out
    input  wire logic [31:0] rdOperand,  // Memory operand
    input  wire logic        extReq,     // Word wanted
    input  wire logic        memRdReq,   // Read wanted
    input  wire logic        memWrReq,   // Store wanted
    input  wire logic [1:0]  memSize,    // Size
    input  wire logic [31:0] memWrData,  // Store data
    input  wire logic        done,       // Retire
    output logic [15:0]      extWord,    // Extension word
    output logic             extValid,   // Word present
    output logic [31:0]      memRdData,  // Operand
    output logic             memRdValid, // Operand present
    output logic             memWrAck,   // Stored
    output logic [31:0]      lastWr      // Last stored value
);
    timeunit 1ns;
    timeprecision 100ps;
    logic tick_q;
    logic second_q;
    logic go;
    assign go = !slow || tick_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tick_q <= 1'b0;
            second_q <= 1'b0;
            lastWr <= 32'h0;
        end else begin
            tick_q <= ~tick_q;
            second_q <= done ? 1'b0 : (second_q || (extReq && extValid));
            if (memWrReq && memWrAck) lastWr <= memWrData;
        end
    end
    // Idle lines toggle so a stale value is never mistaken for data
    assign extValid = extReq && go;
    assign extWord = !extValid ? ~immData[15:0] ^ {16{tick_q}} :
        (memSize == SIZE_LONG && !second_q) ? immData[31:16] : immData[15:0];
    assign memRdValid = memRdReq && go;
    assign memRdData = memRdValid ? rdOperand : ~rdOperand ^ {32{tick_q}};
    assign memWrAck = memWrReq && go;
endmodule : bus_unit_model

// ==== tb/logical_or_execute_tb.sv ====
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module logical_or_execute_tb
    import logical_or_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, arst_n, opValid, regWr, regRd, slow, sawDone, sawIll;
    logic [15:0] opWord, w;
    logic [ADDR_W-1:0] regAddr;
    logic [31:0] regWrData, immData, rdOperand, seed, a, b, t, ex, got;
    logic [7:0] fl;
    logic [2:0] r;
    logic [1:0] sz;
    int errors, testsRun, kind;
    wire logic opReady, extReq, memRdReq, memWrReq, illegal, done, extValid, memRdValid, memWrAck;
    wire logic [1:0] memSize;
    wire logic [2:0] eaMode, eaReg;
    wire logic [7:0] flagByte;
    wire logic [15:0] extWord;
    wire logic [31:0] memWrData, regRdData, memRdData, lastWr;
    logic [15:0] bad [9] = '{16'hc048, 16'hc188, 16'hc580, 16'hc5fc, 16'hc5ba, 16'h0048, 16'h007c, 16'h00c0, 16'hc0c0};
    logical_or_execute u_logical_or_execute (.mclk(mclk), .arst_n(arst_n), .opWord(opWord), .opValid(opValid),
        .opReady(opReady), .extReq(extReq), .extWord(extWord), .extValid(extValid), .memRdReq(memRdReq),
        .memWrReq(memWrReq), .eaMode(eaMode), .eaReg(eaReg), .memSize(memSize), .memRdData(memRdData),
        .memRdValid(memRdValid), .memWrData(memWrData), .memWrAck(memWrAck), .illegal(illegal), .done(done),
        .flagByte(flagByte), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData));
    bus_unit_model u_bus_unit_model (.mclk(mclk), .arst_n(arst_n), .slow(slow), .immData(immData),
        .rdOperand(rdOperand), .extReq(extReq), .memRdReq(memRdReq), .memWrReq(memWrReq), .memSize(memSize),
        .memWrData(memWrData), .done(done), .extWord(extWord), .extValid(extValid), .memRdData(memRdData),
        .memRdValid(memRdValid), .memWrAck(memWrAck), .lastWr(lastWr));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    function automatic logic [31:0] szMask(input logic [1:0] s);
        return (s == SIZE_BYTE) ? 32'h0000_00ff : (s == SIZE_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
    endfunction : szMask
    function automatic logic [7:0] nzFlags(input logic [1:0] s, input logic [31:0] v, input logic x);
        logic n;
        n = (s == SIZE_BYTE) ? v[7] : (s == SIZE_WORD) ? v[15] : v[31];
        return {3'h0, x, n, v == 32'h0, 2'h0};
    endfunction : nzFlags
    task automatic printVerdict();
        if (errors == 0 && testsRun > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : printVerdict
    task automatic regWrite(input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= ad;
        regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : regWrite
    task automatic regRead(input logic [7:0] ad, output logic [31:0] d);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask : regRead
    task automatic doOp(input logic [15:0] ow, input logic [31:0] imm, input logic [31:0] opnd);
        @(posedge mclk);
        opWord <= ow;
        opValid <= 1'b1;
        immData <= imm;
        rdOperand <= opnd;
        @(posedge mclk);
        opValid <= 1'b0;
        #1;
        for (int i = 0; i < 40; i++) begin
            if (done === 1'b1 || illegal === 1'b1) break;
            @(posedge mclk);
            #1;
        end
        sawDone = done === 1'b1;
        sawIll = illegal === 1'b1;
    endtask : doOp
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        printVerdict();
    end
    initial begin
        {arst_n, opValid, regWr, regRd, slow, opWord, regAddr, regWrData, immData, rdOperand} = '0;
        seed = 32'h91db;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            regRead(8'(i * 4), got);
            `CHK(got, DREG_RST)
        end
        regRead(OFS_FLAGS, got);
        `CHK(got, {24'h0, FLAG_RST})
        regRead(OFS_CTRL, got);
        `CHK(got[CTRL_ENABLE], CTRL_EN_RST)
        regRead(8'h40, got);
        `CHK(got, 32'h0)
        // First rounds use zero operands so the zero flag is set at every size
        for (int i = 0; i < 48; i++) begin
            kind = i % 4;
            t = rnd();
            sz = 2'(t[31:16] % 3);
            r = t[2:0];
            fl = {3'h0, t[12:8]};
            a = (i < 6) ? 32'h0 : rnd();
            b = (i < 6) ? 32'h0 : rnd();
            regWrite(OFS_FLAGS, 32'(fl));
            slow <= t[5];
            regWrite({3'h0, r, 2'h0}, a);
            case (kind)
                0: w = {IMM_GROUP, sz, MODE_DREG, r};
                1: w = {OR_GROUP, r, 1'b0, sz, t[6] ? {MODE_EXT, EXT_IMM} : {MODE_IND, 3'h0}};
                2: w = {OR_GROUP, r, 1'b1, sz, MODE_IND, 3'h0};
                default: w = {IMM_GROUP, sz, MODE_IND, 3'h0};
            endcase
            doOp(w, b, (kind == 3) ? a : b);
            ex = (a | b) & szMask(sz);
            `CHK({memSize, eaMode, eaReg}, {sz, w[5:0]})
            `CHK(sawDone, 1'b1)
            regRead({3'h0, r, 2'h0}, got);
            `CHK(got, (kind < 2) ? ((a & ~szMask(sz)) | ex) : a)
            if (kind >= 2) `CHK(lastWr, ex)
            regRead(OFS_FLAGS, got);
            `CHK(got, {24'h0, nzFlags(sz, ex, fl[FLAG_X])})
        end
        for (int j = 0; j < 9; j++) begin
            doOp(bad[j], 32'h0, 32'h0);
            `CHK(sawIll, 1'b1)
            regRead(OFS_STATUS, got);
            `CHK(got[STAT_ILLEGAL], 1'b1)
            regWrite(OFS_STATUS, 32'h2);
        end
        for (int j = 0; j < 6; j++) begin
            t = rnd();
            fl = {3'h0, t[20:16]};
            regWrite(OFS_FLAGS, 32'(fl));
            doOp(FLAG_FORM_WORD, t, 32'h0);
            regRead(OFS_FLAGS, got);
            `CHK(got, {24'h0, (fl | t[7:0]) & FLAG_IMPL_MASK})
        end
        regWrite(OFS_CTRL, 32'h0);
        #1;
        `CHK(opReady, 1'b0)
        regWrite(OFS_CTRL, 32'h1);
        printVerdict();
    end
endmodule : logical_or_execute_tb
